// file: dv/fetch_model.sv
// fetch path partner: offers instruction words and return pushes
`timescale 1ns/100ps
`include "return_exec_defines.svh"

module fetch_model
    import return_exec_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic [1:0]           phase,
    input  wire logic                 instr_ready,
    input  wire logic                 push_ready,
    output logic                      instr_valid,
    output logic [15:0]               instr_word,
    output logic                      push_req,
    output logic [`PC_WIDTH-1:0]      push_value
);
    initial begin
        instr_valid = 1'b0;
        instr_word  = 16'hffff;
        push_req    = 1'b0;
        push_value  = 21'h00_0000;
    end

    // ==========================================
    // instruction offer
    task automatic send_instr(input logic [15:0] w);
        logic ok;
        @(posedge clk_sys);
        instr_word  <= w;
        instr_valid <= 1'b1;
        do begin
            @(negedge clk_sys);
            ok = (phase == PH_Q1) && instr_ready;
            @(posedge clk_sys);
        end while (!ok);
        instr_valid <= 1'b0;
        // released word shows garbage, not the last value
        instr_word  <= ~w;
    endtask : send_instr

    // ==========================================
    // back-to-back pushes, each held until accepted
    task automatic push_list(input logic [`PC_WIDTH-1:0] v [$]);
        logic ok;
        @(posedge clk_sys);
        push_req <= 1'b1;
        foreach (v[i]) begin
            push_value <= v[i];
            do begin
                @(negedge clk_sys);
                ok = push_ready;
                @(posedge clk_sys);
            end while (!ok);
        end
        push_req   <= 1'b0;
        push_value <= ~v[$];
    endtask : push_list
endmodule : fetch_model

// file: dv/return_instruction_exec_tb.sv
// self-checking bench for the return-instruction execute block
`timescale 1ns/100ps
`include "return_exec_defines.svh"

module return_instruction_exec_tb
    import return_exec_pkg::*;
;
    logic        clk_sys, rst_b, instr_valid, push_req, push_ready;
    logic        instr_ready, fetch_flush, pc_load;
    logic        high_prio_global_irq_enable, low_prio_global_irq_enable;
    logic [15:0] instr_word;
    logic [1:0]  phase, clr;
    logic [4:0]  wr_stb;
    logic [7:0]  core_write_data, working_reg, flags_reg, bank_select;
    logic [7:0]  pc_upper_latch, pc_high_latch;
    logic [7:0]  working_shadow, flags_shadow, bank_select_shadow;
    logic [`PC_WIDTH-1:0]        push_value, pc_value, stack_top_value;
    logic [`STACK_PTR_WIDTH-1:0] stack_count;
    int          n_fail, num_checks, cycles;

    return_instruction_exec uut (
        .clk_sys, .rst_b, .instr_valid, .instr_word, .push_req, .push_value,
        .core_write_working(wr_stb[4]), .core_write_flags(wr_stb[3]),
        .core_write_bank(wr_stb[2]), .core_write_latch_upper(wr_stb[1]),
        .core_write_latch_high(wr_stb[0]), .core_write_data,
        .working_shadow, .flags_shadow, .bank_select_shadow,
        .clear_high_prio_enable(clr[1]), .clear_low_prio_enable(clr[0]),
        .phase, .instr_ready, .push_ready, .fetch_flush, .pc_load,
        .pc_value, .stack_top_value, .stack_count, .working_reg,
        .flags_reg, .bank_select, .pc_upper_latch, .pc_high_latch,
        .high_prio_global_irq_enable, .low_prio_global_irq_enable
    );

    fetch_model fm (
        .clk_sys, .phase, .instr_ready, .push_ready,
        .instr_valid, .instr_word, .push_req, .push_value
    );

    // ==========================================
    // clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ==========================================
    // shared tasks
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic core_wr(input logic [7:0] d);
        @(posedge clk_sys);
        wr_stb          <= 5'h1f;
        core_write_data <= d;
        @(posedge clk_sys);
        wr_stb <= 5'h00;
        #1;
        check("working_reg", working_reg, d);
        check("pc_high_latch", pc_high_latch, d);
    endtask : core_wr

    // latches hold 3c from core_wr throughout
    task automatic ret(input logic [15:0] w, input logic [20:0] pc,
                       input logic [20:0] top, input logic [4:0] cnt);
        fm.send_instr(w);
        repeat (2) @(posedge clk_sys);
        #1;
        check("pc_load early", pc_load, 1'b0);
        @(posedge clk_sys);
        #1;
        check("pc_load", pc_load, 1'b1);
        check("pc_value", pc_value, pc);
        check("stack_top_value", stack_top_value, top);
        check("stack_count", stack_count, cnt);
        check("fetch_flush", fetch_flush, 1'b1);
        check("instr_ready", instr_ready, 1'b0);
        @(posedge clk_sys);
        #1;
        check("pc_load pulse", pc_load, 1'b0);
        check("pc_upper_latch", pc_upper_latch, 8'h3c);
        check("pc_high_latch", pc_high_latch, 8'h3c);
    endtask : ret

    task automatic regs(input logic [7:0] w, f, b);
        check("working_reg", working_reg, w);
        check("flags_reg", flags_reg, f);
        check("bank_select", bank_select, b);
    endtask : regs

    task automatic enables(input logic h, l);
        check("high_en", high_prio_global_irq_enable, h);
        check("low_en", low_prio_global_irq_enable, l);
    endtask : enables

    // ==========================================
    // scenarios
    task automatic t_reset();
        check("stack_count", stack_count, 5'h00);
        check("instr_ready", instr_ready, 1'b1);
        check("push_ready", push_ready, 1'b1);
        check("phase", phase, 2'h0);
        regs(8'h00, 8'h00, 8'h00);
        enables(1'b0, 1'b0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_sub();
        core_wr(8'h3c);
        fm.push_list('{21'h01_2345, 21'h0a_bcde, 21'h1f_ffff, 21'h15_5555});
        #1;
        check("stack_count", stack_count, 5'h04);
        check("stack_top_value", stack_top_value, 21'h15_5555);
        ret(16'h0012, 21'h15_5555, 21'h1f_ffff, 5'h03);
        regs(8'h3c, 8'h3c, 8'h3c);
        enables(1'b0, 1'b0);
        ret(16'h0013, 21'h1f_ffff, 21'h0a_bcde, 5'h02);
        regs(8'ha1, 8'hb2, 8'hc3);
        $display("test subroutine return done");
    endtask : t_sub

    task automatic t_irq();
        core_wr(8'h3c);
        ret(16'h0010, 21'h0a_bcde, 21'h01_2345, 5'h01);
        regs(8'h3c, 8'h3c, 8'h3c);
        enables(1'b1, 1'b0);
        // high already set, so the low one must come up now
        ret(16'h0011, 21'h01_2345, 21'h00_0000, 5'h00);
        regs(8'ha1, 8'hb2, 8'hc3);
        enables(1'b1, 1'b1);
        @(posedge clk_sys);
        clr <= 2'h3;
        @(posedge clk_sys);
        clr <= 2'h0;
        #1;
        enables(1'b0, 1'b0);
        $display("test interrupt return done");
    endtask : t_irq

    task automatic t_lit();
        fm.push_list('{21'h0c_0ffe});
        // neighbour of the literal opcode must do nothing
        fm.send_instr(16'h0d5a);
        repeat (4) @(posedge clk_sys);
        #1;
        check("stack_count", stack_count, 5'h01);
        check("pc_load", pc_load, 1'b0);
        ret(16'h0c5a, 21'h0c_0ffe, 21'h00_0000, 5'h00);
        regs(8'h5a, 8'hb2, 8'hc3);
        enables(1'b0, 1'b0);
        $display("test literal return done");
    endtask : t_lit

    // push lands in Q3 just before the pop, so the pushed value returns
    task automatic t_push_pop();
        fm.send_instr(16'h0012);
        fm.push_list('{21'h1a_2b3c});
        #1;
        check("push_ready in pop", push_ready, 1'b0);
        check("stack_count", stack_count, 5'h01);
        @(posedge clk_sys);
        #1;
        check("pc_load", pc_load, 1'b1);
        check("pc_value", pc_value, 21'h1a_2b3c);
        check("stack_count", stack_count, 5'h00);
        regs(8'h5a, 8'hb2, 8'hc3);
        $display("test push before pop done");
    endtask : t_push_pop

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // ==========================================
    // main sequence
    initial begin
        rst_b              = 1'b0;
        wr_stb             = 5'h00;
        clr                = 2'h0;
        core_write_data    = 8'h00;
        working_shadow     = 8'ha1;
        flags_shadow       = 8'hb2;
        bank_select_shadow = 8'hc3;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        t_reset();
        t_sub();
        t_irq();
        t_lit();
        t_push_pop();
        print_verdict();
    end
endmodule : return_instruction_exec_tb

// file: rtl/return_instruction_exec.sv
// decode and execute of the three return instructions, with return stack
// Overview of operation
// (RL1) irq_exit_op pops the stack and loads stack_top_value into the pc.
// (RL2) irq_exit_op sets the high or low global enable, no other flags.
// (RL3) irq_exit_op with fast bit 1 restores working, flags, bank_select.
// (RL4) subroutine return pops the stack, stack_top_value goes to the pc.
// (RL5) subroutine return, fast bit 1, restores from shadows; flags else kept.
// (RL6) fast bit 0: working, flags and bank_select are not restored.
// (RL7) returns never alter pc_upper_latch or pc_high_latch.
// (RL8) literal_exit_op writes its 8-bit literal to working and pops the pc.
// (RL9) return stack is last-in first-out; pop exposes the next-lower entry.
// (RL10) returns take two cycles: pop in Q4, second cycle a forced no-op.
`timescale 1ns/100ps
`include "return_exec_defines.svh"
module return_instruction_exec
    import return_exec_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    input  wire logic                       instr_valid,
    input  wire logic [15:0]                instr_word,
    input  wire logic                       push_req,
    input  wire logic [`PC_WIDTH-1:0]       push_value,
    input  wire logic                       core_write_working,
    input  wire logic                       core_write_flags,
    input  wire logic                       core_write_bank,
    input  wire logic                       core_write_latch_upper,
    input  wire logic                       core_write_latch_high,
    input  wire logic [`DATA_WIDTH-1:0]     core_write_data,
    input  wire logic [`DATA_WIDTH-1:0]     working_shadow,
    input  wire logic [`DATA_WIDTH-1:0]     flags_shadow,
    input  wire logic [`DATA_WIDTH-1:0]     bank_select_shadow,
    input  wire logic                       clear_high_prio_enable,
    input  wire logic                       clear_low_prio_enable,
    output logic [1:0]                      phase,
    output logic                            instr_ready,
    output logic                            push_ready,
    output logic                            fetch_flush,
    output logic                            pc_load,
    output logic [`PC_WIDTH-1:0]            pc_value,
    output logic [`PC_WIDTH-1:0]            stack_top_value,
    output logic [`STACK_PTR_WIDTH-1:0]     stack_count,
    output logic [`DATA_WIDTH-1:0]          working_reg,
    output logic [`DATA_WIDTH-1:0]          flags_reg,
    output logic [`DATA_WIDTH-1:0]          bank_select,
    output logic [`DATA_WIDTH-1:0]          pc_upper_latch,
    output logic [`DATA_WIDTH-1:0]          pc_high_latch,
    output logic                            high_prio_global_irq_enable,
    output logic                            low_prio_global_irq_enable
);
    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // ========================================================
    // decode
    function automatic ret_kind_type decode_ret(input logic [15:0] w);
        if ((w & `OP_FAST_MASK) == `OP_IRQ_EXIT) begin
            decode_ret = RET_IRQ;
        end else if ((w & `OP_FAST_MASK) == `OP_SUB_EXIT) begin
            decode_ret = RET_SUB;
        end else if (w[15:8] == `OP_LIT_UPPER) begin
            decode_ret = RET_LIT;
        end else begin
            decode_ret = RET_NONE;
        end
    endfunction : decode_ret
    phase_type                   phase_q;
    ret_kind_type                kind_q;
    logic                        fast_q;
    logic [`DATA_WIDTH-1:0]      literal_q;
    logic                        flush_q;
    logic                        pc_load_q;
    logic [`PC_WIDTH-1:0]        pc_q;
    logic [`PC_WIDTH-1:0]        top_q;
    logic [`PC_WIDTH-1:0]        stack_mem [0:`STACK_DEPTH-2];
    logic [`STACK_PTR_WIDTH-1:0] count_q;
    logic [`DATA_WIDTH-1:0]      working_q, flags_q, bank_q;
    logic [`DATA_WIDTH-1:0]      latch_upper_q, latch_high_q;
    logic                        gie_high_q, gie_low_q;
    logic                        take, do_pop, do_push, fast_restore;
    // instructions are taken only in Q1 and never during the forced no-op
    assign instr_ready  = (phase_q == PH_Q1) && !flush_q;
    assign take         = instr_ready && instr_valid;
    assign do_pop       = (phase_q == PH_Q4) && (kind_q != RET_NONE); // RL10
    // a pop and a push in one cycle would race on the top entry
    assign push_ready   = !do_pop && (count_q != `PTR_FULL);
    assign do_push      = push_req && push_ready;
    assign fast_restore = do_pop && fast_q && (kind_q != RET_LIT);  // RL3 RL5 RL6
    assign phase           = phase_q;
    assign fetch_flush     = flush_q;
    assign pc_load         = pc_load_q;
    assign pc_value        = pc_q;
    assign stack_top_value = top_q;
    assign stack_count     = count_q;
    assign working_reg     = working_q;
    assign flags_reg       = flags_q;
    assign bank_select     = bank_q;
    assign pc_upper_latch  = latch_upper_q;
    assign pc_high_latch   = latch_high_q;
    assign high_prio_global_irq_enable = gie_high_q;
    assign low_prio_global_irq_enable  = gie_low_q;
    // ========================================================
    // phase sequencer and instruction capture
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            phase_q <= PH_Q1;
        end else begin
            case (phase_q)
                PH_Q1:   phase_q <= PH_Q2;
                PH_Q2:   phase_q <= PH_Q3;
                PH_Q3:   phase_q <= PH_Q4;
                default: phase_q <= PH_Q1;
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            kind_q    <= RET_NONE;
            fast_q    <= 1'b0;
            literal_q <= `DATA_RESET;
        end else if (take) begin
            kind_q    <= decode_ret(instr_word);
            fast_q    <= instr_word[`OP_FAST_BIT];
            literal_q <= instr_word[`DATA_WIDTH-1:0];
        end else if (do_pop) begin
            kind_q    <= RET_NONE;
        end
    end
    // second instruction cycle runs as a no-op while fetch refills
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            flush_q <= 1'b0;
        end else if (do_pop) begin
            flush_q <= 1'b1; // RL10
        end else if (phase_q == PH_Q4) begin
            flush_q <= 1'b0;
        end
    end

    // ========================================================
    // program counter load; latches are left alone
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pc_q      <= `PC_RESET;
            pc_load_q <= 1'b0;
        end else begin
            pc_load_q <= do_pop;
            if (do_pop) begin
                pc_q <= top_q; // RL1 RL4 RL8
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            latch_upper_q <= `DATA_RESET;
            latch_high_q  <= `DATA_RESET;
        end else begin
            // only core writes reach the latches, never a return RL7
            if (core_write_latch_upper) begin
                latch_upper_q <= core_write_data;
            end
            if (core_write_latch_high) begin
                latch_high_q <= core_write_data;
            end
        end
    end
    // return stack: top held apart, lower entries in the array
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            top_q   <= `PC_RESET;
            count_q <= `PTR_RESET;
        end else if (do_pop) begin
            // underflow leaves zero on top
            if (count_q >= `PTR_TWO) begin
                top_q <= stack_mem[count_q - `PTR_TWO]; // RL9
            end else begin
                top_q <= `PC_RESET;
            end
            if (count_q != `PTR_RESET) begin
                count_q <= count_q - `PTR_ONE;
            end
        end else if (do_push) begin
            top_q   <= push_value; // RL9
            count_q <= count_q + `PTR_ONE;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (do_push && count_q != `PTR_RESET) begin
            stack_mem[count_q - `PTR_ONE] <= top_q; // RL9
        end
    end
    // ========================================================
    // working, flags and bank select
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            working_q <= `DATA_RESET;
        end else if (do_pop && kind_q == RET_LIT) begin
            working_q <= literal_q; // RL8
        end else if (fast_restore) begin
            working_q <= working_shadow; // RL3 RL5
        end else if (core_write_working) begin
            working_q <= core_write_data;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            flags_q <= `DATA_RESET;
            bank_q  <= `DATA_RESET;
        end else begin
            if (fast_restore) begin
                flags_q <= flags_shadow; // RL3 RL5
            end else if (core_write_flags) begin
                flags_q <= core_write_data;
            end
            if (fast_restore) begin
                bank_q <= bank_select_shadow; // RL3 RL5
            end else if (core_write_bank) begin
                bank_q <= core_write_data;
            end
        end
    end
    // global enables: high priority first, else low; set beats clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            gie_high_q <= 1'b0;
            gie_low_q  <= 1'b0;
        end else begin
            if (do_pop && kind_q == RET_IRQ && !gie_high_q) begin
                gie_high_q <= 1'b1; // RL2
            end else if (clear_high_prio_enable) begin
                gie_high_q <= 1'b0;
            end
            if (do_pop && kind_q == RET_IRQ && gie_high_q) begin
                gie_low_q <= 1'b1; // RL2
            end else if (clear_low_prio_enable) begin
                gie_low_q <= 1'b0;
            end
        end
    end

    // ========================================================
    // checks
    property p_pop_loads_pc;
        do_pop |=> pc_load && pc_q == $past(top_q);
    endproperty
    a_pop_loads_pc: assert property (p_pop_loads_pc) // RL1
        else $error("pc not loaded from stack top");
    property p_return_timing;
        take && decode_ret(instr_word) != RET_NONE |-> ##3 do_pop;
    endproperty
    a_return_timing: assert property (p_return_timing) // RL10
        else $error("return did not pop in Q4");
    property p_flush_cycle;
        do_pop |=> fetch_flush [*4] ##1 !fetch_flush;
    endproperty
    a_flush_cycle: assert property (p_flush_cycle) // RL10
        else $error("forced no-op cycle wrong length");
    property p_irq_sets_enable;
        do_pop && kind_q == RET_IRQ |=> gie_high_q && $past(gie_high_q) == 1'b0
            || gie_low_q;
    endproperty
    a_irq_sets_enable: assert property (p_irq_sets_enable) // RL2
        else $error("irq exit did not set an enable");
    property p_fast_restore;
        fast_restore |=> working_q == $past(working_shadow) && flags_q ==
            $past(flags_shadow) && bank_q == $past(bank_select_shadow);
    endproperty
    a_fast_restore: assert property (p_fast_restore) // RL3
        else $error("shadow copies not restored");
    property p_no_restore;
        do_pop && !fast_q && !core_write_flags && !core_write_bank
            |=> $stable(flags_q) && $stable(bank_q);
    endproperty
    a_no_restore: assert property (p_no_restore) // RL6
        else $error("registers changed without fast bit");
    property p_latches_kept;
        do_pop && !core_write_latch_upper && !core_write_latch_high
            |=> $stable(latch_upper_q) && $stable(latch_high_q);
    endproperty
    a_latches_kept: assert property (p_latches_kept) // RL7
        else $error("pc latch changed by return");
    property p_literal_write;
        do_pop && kind_q == RET_LIT && !core_write_flags
            |=> working_q == $past(literal_q) && $stable(flags_q);
    endproperty
    a_literal_write: assert property (p_literal_write) // RL8
        else $error("literal not written to working");
    property p_lifo;
        do_push ##1 do_pop |=> top_q == $past(top_q, 2);
    endproperty
    a_lifo: assert property (p_lifo) // RL9
        else $error("pop did not expose lower entry");
    property p_sub_pop_count;
        do_pop && kind_q == RET_SUB && count_q != `PTR_RESET
            |=> count_q == $past(count_q) - `PTR_ONE;
    endproperty
    a_sub_pop_count: assert property (p_sub_pop_count) // RL4
        else $error("subroutine return did not pop");
    c_irq_fast: cover property (fast_restore && kind_q == RET_IRQ);
    c_sub_plain: cover property (do_pop && kind_q == RET_SUB && !fast_q);
    c_literal: cover property (do_pop && kind_q == RET_LIT);
    c_push_pop: cover property (do_push ##1 do_pop);
endmodule : return_instruction_exec

// file: shared/return_exec_defines.svh
// constants for the return-instruction execute block
`ifndef RETURN_EXEC_DEFINES_SVH
`define RETURN_EXEC_DEFINES_SVH

`define PC_WIDTH          21
`define STACK_DEPTH       31
`define STACK_PTR_WIDTH   5
`define DATA_WIDTH        8

// 0000 0000 0001 000s and 0000 0000 0001 001s, s in bit 0
`define OP_IRQ_EXIT       16'h0010
`define OP_SUB_EXIT       16'h0012
`define OP_FAST_MASK      16'hfffe
`define OP_FAST_BIT       0
// 0000 1100 kkkk kkkk
`define OP_LIT_UPPER      8'h0c

`define PC_RESET          21'h00_0000
`define DATA_RESET        8'h00
`define PTR_RESET         5'h00
`define PTR_ONE           5'h01
`define PTR_TWO           5'h02
`define PTR_FULL          5'h1f

`endif

// file: shared/return_exec_pkg.sv
// types shared by the return-instruction execute block
package return_exec_pkg;

    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_type;

    typedef enum logic [1:0] {
        RET_NONE,
        RET_IRQ,
        RET_SUB,
        RET_LIT
    } ret_kind_type;

endpackage : return_exec_pkg
